// ---- rlsc_pkg.sv ----
// package: offsets, fields, reset values and constants of the loss-of-signal control bank
`default_nettype none

package rlsc_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] RLSC_ADDR_ENABLE    = 8'h0A;
  localparam logic [7:0] RLSC_ADDR_FLAGS     = 8'h0B;
  localparam logic [7:0] RLSC_ADDR_LEVEL_LO  = 8'h0C;
  localparam logic [7:0] RLSC_ADDR_LEVEL_HYS = 8'h0D;
  localparam logic [7:0] RLSC_ADDR_PEAK_LO   = 8'h0F;

  // values after reset
  localparam logic [7:0] RLSC_ENABLE_RST    = 8'h01;
  localparam logic [7:0] RLSC_FLAGS_RST     = 8'h00;
  localparam logic [7:0] RLSC_LEVEL_LO_RST  = 8'h0F;
  localparam logic [7:0] RLSC_LEVEL_HYS_RST = 8'h70;
  localparam logic [9:0] RLSC_PEAK_RST      = 10'h000;

  // field positions in loss_detect_enable
  localparam int RLSC_EN_ANALOG_BIT = 0;
  localparam int RLSC_EN_DMODE_LSB  = 1;
  localparam int RLSC_EN_SQM_BIT    = 3;

  // field positions in loss_detect_flags
  localparam int RLSC_FL_LOSS_BIT = 0;
  localparam int RLSC_FL_ANA_BIT  = 1;
  localparam int RLSC_FL_DIG_BIT  = 2;
  localparam int RLSC_FL_LAST_BIT = 3;
  localparam int RLSC_FL_SQM_BIT  = 4;

  // field positions in analog_loss_level_high_hyst
  localparam int RLSC_HH_THR_LSB  = 0;
  localparam int RLSC_HH_HYST_LSB = 4;

  // analog hysteresis base, run-length scaling and quality monitor width
  localparam logic [4:0]  RLSC_HYST_BASE    = 5'h10;
  localparam int          RLSC_FIELD_BITS   = 1024;
  localparam logic [9:0]  RLSC_FIELD_LAST   = 10'(RLSC_FIELD_BITS - 1);
  localparam logic [10:0] RLSC_ASSERT_MULT  = 11'h005;
  localparam logic [10:0] RLSC_ASSERT_ADD   = 11'h002;
  localparam logic [11:0] RLSC_CLEAR_MULT   = 12'h010;
  localparam logic [11:0] RLSC_CLEAR_ADD    = 12'h001;
  localparam int          RLSC_SQM_W        = 16;

  // digital loss trigger modes
  typedef enum logic [1:0] {
    RLSC_DMODE_OFF    = 2'h0,
    RLSC_DMODE_ZEROS  = 2'h1,
    RLSC_DMODE_ONES   = 2'h2,
    RLSC_DMODE_EITHER = 2'h3
  } rlsc_dmode_t;

  // run-length detector states
  typedef enum logic [2:0] {
    RLSC_DL_IDLE  = 3'b001,
    RLSC_DL_WATCH = 3'b010,
    RLSC_DL_LOST  = 3'b100
  } rlsc_dl_state_t;

  // mode is not disabled
  function automatic logic rlsc_mode_on(input rlsc_dmode_t mode);
    rlsc_mode_on = (mode != RLSC_DMODE_OFF);
  endfunction

  // mode accepts a run made of this bit value
  function automatic logic rlsc_mode_takes(input rlsc_dmode_t mode, input logic bit_value);
    case (mode)
      RLSC_DMODE_ZEROS:  rlsc_mode_takes = !bit_value;
      RLSC_DMODE_ONES:   rlsc_mode_takes = bit_value;
      RLSC_DMODE_EITHER: rlsc_mode_takes = 1'b1;
      default:           rlsc_mode_takes = 1'b0;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- rlsc_ana_if.sv ----
// interface: settings and result between the control bank and the analog detector
`default_nettype none

interface rlsc_ana_if;
  logic [9:0] threshold;
  logic [3:0] hysteresis;
  logic       peak_valid;
  logic [9:0] peak_value;
  logic       clear;
  logic       loss;

  modport ctrl (output threshold, output hysteresis, output peak_valid,
                output peak_value, output clear, input loss);
  modport det  (input threshold, input hysteresis, input peak_valid,
                input peak_value, input clear, output loss);
endinterface

`default_nettype wire

// ---- rlsc_analog_detect.sv ----
// module: analog amplitude loss detector with hysteresis
`default_nettype none

module rlsc_analog_detect
  import rlsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // settings, samples and result
  rlsc_ana_if.det  ana
);

  logic [14:0] deassert_scaled;
  logic [14:0] peak_scaled;
  logic        below_level;

  // compare at 16x scale so the hysteresis division never truncates
  assign deassert_scaled = 15'(ana.threshold) * 15'(5'(ana.hysteresis) + RLSC_HYST_BASE); // [R14]
  assign peak_scaled     = {1'b0, ana.peak_value, 4'h0};
  assign below_level     = ana.peak_value < ana.threshold;

  // loss sets below threshold, releases only above the raised level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ana.loss <= 1'b0;
    end else if (ana.clear) begin
      ana.loss <= 1'b0;
    end else if (ana.peak_valid) begin
      if (!ana.loss && below_level) begin
        ana.loss <= 1'b1; // [R22]
      end else if (ana.loss && (peak_scaled > deassert_scaled)) begin
        ana.loss <= 1'b0; // [R22] [R14]
      end
    end
  end

endmodule

`default_nettype wire

// ---- rlsc_ctrl.sv ----
// module: receiver loss-of-signal control and status bank with run-length detector
//
// How it works
// (R1) quality alarm feeds loss only when enabled
// (R2) mode field picks zeros, ones, either run
// (R3) analog detector feeds loss only when enabled
// (R4) enable register resets to analog only
// (R5) quality flag high while value below threshold
// (R6) lock loss forces quality flag low
// (R7) last-bit flag keeps bit of latest event
// (R8) status bit 2 shows digital loss
// (R9) status bit 1 shows analog loss
// (R10) status bit 0 equals the loss pin
// (R11) threshold low byte in its own register
// (R12) threshold top bits 1:0, bits 3:2 zero
// (R13) software keeps threshold 10 to 400
// (R14) release level is threshold times (h+16)/16
// (R15) threshold low byte resets to 0x0F
// (R16) second threshold register resets to 0x70
// (R17) peak amplitude low byte read-only, resets zero
// (R18) software reads peak low byte first
// (R19) pin is OR of enabled loss sources
// (R20) digital loss at (n*5+2)*1024 identical bits
// (R21) digital clear after (n*16+1) transition fields
// (R22) analog loss with hysteresis on release
`default_nettype none

module rlsc_ctrl
  import rlsc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // receive-side software reset
  input  wire logic             sw_reset,
  // recovered bit stream
  input  wire logic             rx_bit_valid,
  input  wire logic             rx_bit,
  // peak detector measurement
  input  wire logic             peak_valid,
  input  wire logic [9:0]       peak_value,
  // quality monitor and lock
  input  wire logic [RLSC_SQM_W-1:0] sqm_value,
  input  wire logic [RLSC_SQM_W-1:0] sqm_threshold,
  input  wire logic             lock_loss,
  // run-length counts from the neighbouring registers
  input  wire logic [7:0]       digital_loss_assert_count,
  input  wire logic [7:0]       digital_loss_clear_count,
  // alarm pin and peak upper bits snapshot
  output logic                  signal_loss_pin,
  output logic      [1:0]       peak_amplitude_high
);

  // control fields and captured peak amplitude
  logic           analog_loss_enable;
  rlsc_dmode_t    digital_loss_mode;
  logic           quality_monitor_loss_enable;
  logic [9:0]     analog_loss_threshold;
  logic [3:0]     analog_loss_hysteresis;
  logic [9:0]     peak_amplitude;

  // status
  logic           quality_monitor_loss;
  logic           digital_loss;
  logic           digital_loss_last_bit;
  logic           analog_loss;
  logic           next_signal_loss;

  // run-length detector
  rlsc_dl_state_t dl_state;
  logic           run_bit;
  logic [20:0]    run_len;
  logic [20:0]    next_run_len;
  logic [20:0]    assert_bits;
  logic [10:0]    assert_units;
  logic [11:0]    clear_need;
  logic [11:0]    clear_fields;
  logic [11:0]    next_clear_fields;
  logic [9:0]     field_cnt;
  logic           field_edge;
  logic           same_bit;
  logic           edge_now;
  logic           field_end;
  logic           run_trips;
  logic           clear_done;

  // register decode and readback
  logic           wr_enable;
  logic           wr_level_lo;
  logic           wr_level_hys;
  logic [7:0]     next_rdata;

  rlsc_ana_if ana ();

  // analog detector hookup
  assign ana.threshold  = analog_loss_threshold;
  assign ana.hysteresis = analog_loss_hysteresis;
  assign ana.peak_valid = peak_valid;
  assign ana.peak_value = peak_value;
  assign ana.clear      = sw_reset;
  assign analog_loss    = ana.loss;

  rlsc_analog_detect u_analog (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ana     (ana)
  );

  // write strobes; writes to read-only offsets fall through unused
  assign wr_enable    = reg_wr && (reg_addr == RLSC_ADDR_ENABLE);
  assign wr_level_lo  = reg_wr && (reg_addr == RLSC_ADDR_LEVEL_LO);
  assign wr_level_hys = reg_wr && (reg_addr == RLSC_ADDR_LEVEL_HYS);

  // loss_detect_enable: read-write low nibble
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      analog_loss_enable          <= RLSC_ENABLE_RST[RLSC_EN_ANALOG_BIT]; // [R4]
      digital_loss_mode           <= rlsc_dmode_t'(RLSC_ENABLE_RST[RLSC_EN_DMODE_LSB +: 2]); // [R4]
      quality_monitor_loss_enable <= RLSC_ENABLE_RST[RLSC_EN_SQM_BIT]; // [R4]
    end else if (sw_reset) begin
      analog_loss_enable          <= RLSC_ENABLE_RST[RLSC_EN_ANALOG_BIT]; // [R4]
      digital_loss_mode           <= rlsc_dmode_t'(RLSC_ENABLE_RST[RLSC_EN_DMODE_LSB +: 2]);
      quality_monitor_loss_enable <= RLSC_ENABLE_RST[RLSC_EN_SQM_BIT];
    end else if (wr_enable) begin
      analog_loss_enable          <= reg_wdata[RLSC_EN_ANALOG_BIT];
      digital_loss_mode           <= rlsc_dmode_t'(reg_wdata[RLSC_EN_DMODE_LSB +: 2]); // [R2]
      quality_monitor_loss_enable <= reg_wdata[RLSC_EN_SQM_BIT];
    end
  end

  // analog threshold and hysteresis; reserved bits are simply not stored
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      analog_loss_threshold  <= {RLSC_LEVEL_HYS_RST[RLSC_HH_THR_LSB +: 2], RLSC_LEVEL_LO_RST};
      analog_loss_hysteresis <= RLSC_LEVEL_HYS_RST[RLSC_HH_HYST_LSB +: 4]; // [R16]
    end else if (sw_reset) begin
      analog_loss_threshold  <= {RLSC_LEVEL_HYS_RST[RLSC_HH_THR_LSB +: 2], RLSC_LEVEL_LO_RST}; // [R15]
      analog_loss_hysteresis <= RLSC_LEVEL_HYS_RST[RLSC_HH_HYST_LSB +: 4]; // [R16]
    end else begin
      if (wr_level_lo) begin
        analog_loss_threshold[7:0] <= reg_wdata; // [R11]
      end
      if (wr_level_hys) begin
        analog_loss_threshold[9:8] <= reg_wdata[RLSC_HH_THR_LSB +: 2]; // [R12]
        analog_loss_hysteresis     <= reg_wdata[RLSC_HH_HYST_LSB +: 4]; // [R14]
      end
    end
  end

  // peak amplitude capture; a low-byte read freezes the upper bits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      peak_amplitude      <= RLSC_PEAK_RST; // [R17]
      peak_amplitude_high <= RLSC_PEAK_RST[9:8];
    end else if (sw_reset) begin
      peak_amplitude      <= RLSC_PEAK_RST; // [R17]
      peak_amplitude_high <= RLSC_PEAK_RST[9:8];
    end else begin
      if (peak_valid) begin
        peak_amplitude <= peak_value;
      end
      if (reg_rd && (reg_addr == RLSC_ADDR_PEAK_LO)) begin
        peak_amplitude_high <= peak_amplitude[9:8]; // [R18]
      end
    end
  end

  // quality monitor flag, held down while the receiver is out of lock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      quality_monitor_loss <= 1'b0;
    end else if (sw_reset) begin
      quality_monitor_loss <= 1'b0;
    end else begin
      quality_monitor_loss <= (sqm_value < sqm_threshold) && !lock_loss; // [R5] [R6]
    end
  end

  // run-length arithmetic, all in bits or fields
  assign assert_units = 11'(digital_loss_assert_count) * RLSC_ASSERT_MULT + RLSC_ASSERT_ADD;
  assign assert_bits  = {assert_units, 10'h000}; // [R20]
  assign clear_need   = 12'(digital_loss_clear_count) * RLSC_CLEAR_MULT + RLSC_CLEAR_ADD; // [R21]
  assign same_bit     = (rx_bit == run_bit);
  assign edge_now     = field_edge || !same_bit;
  assign field_end    = (field_cnt == RLSC_FIELD_LAST);
  assign next_clear_fields = edge_now ? (clear_fields + 12'h001) : 12'h000;

  // saturate so a long dead line never wraps back below the trip point
  always_comb begin
    if (!same_bit) begin
      next_run_len = 21'h000001;
    end else if (run_len == 21'h1FFFFF) begin
      next_run_len = run_len;
    end else begin
      next_run_len = run_len + 21'h000001;
    end
  end

  assign run_trips  = (next_run_len >= assert_bits) && rlsc_mode_takes(digital_loss_mode, rx_bit);
  assign clear_done = field_end && edge_now && (next_clear_fields >= clear_need);
  assign digital_loss = (dl_state == RLSC_DL_LOST); // [R8]

  // run tracker follows every received bit while a digital mode is on, cleared while off
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_bit <= 1'b0;
      run_len <= 21'h000000;
    end else if (sw_reset || !rlsc_mode_on(digital_loss_mode)) begin
      run_bit <= 1'b0;
      run_len <= 21'h000000;
    end else if (rx_bit_valid) begin
      run_bit <= rx_bit;
      run_len <= next_run_len; // [R20]
    end
  end

  // digital loss state machine
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dl_state <= RLSC_DL_IDLE;
    end else if (sw_reset) begin
      dl_state <= RLSC_DL_IDLE;
    end else begin
      case (dl_state)
        RLSC_DL_IDLE: begin
          if (rlsc_mode_on(digital_loss_mode)) begin
            dl_state <= RLSC_DL_WATCH; // [R2]
          end
        end
        RLSC_DL_WATCH: begin
          if (!rlsc_mode_on(digital_loss_mode)) begin
            dl_state <= RLSC_DL_IDLE; // [R2]
          end else if (rx_bit_valid && run_trips) begin
            dl_state <= RLSC_DL_LOST; // [R20] [R2]
          end
        end
        RLSC_DL_LOST: begin
          if (!rlsc_mode_on(digital_loss_mode)) begin
            dl_state <= RLSC_DL_IDLE;
          end else if (rx_bit_valid && clear_done) begin
            dl_state <= RLSC_DL_WATCH; // [R21]
          end
        end
        default: begin
          dl_state <= RLSC_DL_IDLE;
        end
      endcase
    end
  end

  // clear-side field counting runs only while loss is held
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      field_cnt    <= 10'h000;
      field_edge   <= 1'b0;
      clear_fields <= 12'h000;
    end else if (sw_reset || (dl_state != RLSC_DL_LOST)) begin
      field_cnt    <= 10'h000;
      field_edge   <= 1'b0;
      clear_fields <= 12'h000;
    end else if (rx_bit_valid) begin
      field_cnt <= field_cnt + 10'h001;
      if (field_end) begin
        field_edge   <= 1'b0;
        clear_fields <= next_clear_fields; // [R21]
      end else begin
        field_edge <= edge_now;
      end
    end
  end

  // bit value of the run behind the latest digital event
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      digital_loss_last_bit <= 1'b0;
    end else if (sw_reset) begin
      digital_loss_last_bit <= 1'b0;
    end else if ((dl_state == RLSC_DL_WATCH) && rlsc_mode_on(digital_loss_mode)
                 && rx_bit_valid && run_trips) begin
      digital_loss_last_bit <= rx_bit; // [R7]
    end
  end

  // combined alarm; each source passes only under its own enable
  assign next_signal_loss = (analog_loss_enable && analog_loss)                 // [R3] [R19]
                         || (rlsc_mode_on(digital_loss_mode) && digital_loss)   // [R19]
                         || (quality_monitor_loss_enable && quality_monitor_loss); // [R1] [R19]

  // pin flop, also the source of status bit 0
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      signal_loss_pin <= 1'b0;
    end else if (sw_reset) begin
      signal_loss_pin <= 1'b0;
    end else begin
      signal_loss_pin <= next_signal_loss;
    end
  end

  // readback mux; reserved bits and unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      RLSC_ADDR_ENABLE: begin
        next_rdata[RLSC_EN_ANALOG_BIT]       = analog_loss_enable;
        next_rdata[RLSC_EN_DMODE_LSB +: 2]   = digital_loss_mode;
        next_rdata[RLSC_EN_SQM_BIT]          = quality_monitor_loss_enable;
      end
      RLSC_ADDR_FLAGS: begin
        next_rdata[RLSC_FL_LOSS_BIT] = signal_loss_pin; // [R10]
        next_rdata[RLSC_FL_ANA_BIT]  = analog_loss; // [R9]
        next_rdata[RLSC_FL_DIG_BIT]  = digital_loss; // [R8]
        next_rdata[RLSC_FL_LAST_BIT] = digital_loss_last_bit; // [R7]
        next_rdata[RLSC_FL_SQM_BIT]  = quality_monitor_loss; // [R5]
      end
      RLSC_ADDR_LEVEL_LO: begin
        next_rdata = analog_loss_threshold[7:0]; // [R11]
      end
      RLSC_ADDR_LEVEL_HYS: begin
        next_rdata[RLSC_HH_THR_LSB +: 2]  = analog_loss_threshold[9:8]; // [R12]
        next_rdata[RLSC_HH_HYST_LSB +: 4] = analog_loss_hysteresis;
      end
      RLSC_ADDR_PEAK_LO: begin
        next_rdata = peak_amplitude[7:0]; // [R17]
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data is registered and held until the next read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ---- rlsc_ctrl_asserts.sv ----
// checker: port-level properties of the loss-of-signal control bank
`default_nettype none

module rlsc_ctrl_asserts
  import rlsc_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  // register port
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  sw_reset,
  // receive side
  input wire logic                  rx_bit_valid,
  input wire logic                  rx_bit,
  input wire logic                  peak_valid,
  input wire logic [9:0]            peak_value,
  input wire logic [RLSC_SQM_W-1:0] sqm_value,
  input wire logic [RLSC_SQM_W-1:0] sqm_threshold,
  input wire logic                  lock_loss,
  input wire logic [7:0]            digital_loss_assert_count,
  input wire logic [7:0]            digital_loss_clear_count,
  // outputs
  input wire logic                  signal_loss_pin,
  input wire logic [1:0]            peak_amplitude_high
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic [3:0] en_q;
  logic [9:0] pk_q;

  // shadow of the enable bits, only used to gate the alarm properties
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) en_q <= RLSC_ENABLE_RST[3:0];
    else if (sw_reset) en_q <= RLSC_ENABLE_RST[3:0];
    else if (reg_wr && reg_addr == RLSC_ADDR_ENABLE) en_q <= reg_wdata[3:0];
  end

  // shadow of the latest peak sample
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pk_q <= RLSC_PEAK_RST;
    else if (sw_reset) pk_q <= RLSC_PEAK_RST;
    else if (peak_valid) pk_q <= peak_value;
  end

  sequence s_rd(logic [7:0] a);
    reg_rd && !sw_reset && reg_addr == a;
  endsequence
  sequence s_wr_lo;
    reg_wr && !reg_rd && !sw_reset && reg_addr == RLSC_ADDR_LEVEL_LO;
  endsequence
  // quality below threshold long enough to pass flag and pin stages
  sequence s_sqm_low;
    (en_q[3] && !sw_reset && !lock_loss && sqm_value < sqm_threshold) [*3];
  endsequence

  AST_EN_RSVD: assert property (
    s_rd(RLSC_ADDR_ENABLE) |=> reg_rdata[7:4] == 4'h0)
    else $error("enable reserved bits not zero");
  AST_HYS_RSVD: assert property (
    s_rd(RLSC_ADDR_LEVEL_HYS) |=> reg_rdata[3:2] == 2'h0)
    else $error("threshold reserved bits not zero");
  AST_FLAG_PIN: assert property (
    s_rd(RLSC_ADDR_FLAGS) |=> reg_rdata[0] == $past(signal_loss_pin))
    else $error("status bit 0 differs from pin");
  AST_LO_RW: assert property (
    s_wr_lo ##1 (!(reg_wr && reg_addr == RLSC_ADDR_LEVEL_LO) && !sw_reset)
      ##1 s_rd(RLSC_ADDR_LEVEL_LO) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("threshold low byte readback wrong");
  AST_SQM_PIN: assert property (
    s_sqm_low |-> signal_loss_pin)
    else $error("enabled quality alarm did not raise pin");
  AST_PIN_OFF: assert property (
    (en_q == 4'h0) [*3] |-> !signal_loss_pin)
    else $error("pin high with all sources off");
  AST_PIN_SWRST: assert property (
    sw_reset |=> !signal_loss_pin)
    else $error("pin not cleared by soft reset");
  AST_PEAK_LOW: assert property (
    s_rd(RLSC_ADDR_PEAK_LO) |=> {peak_amplitude_high, reg_rdata} == $past(pk_q))
    else $error("peak read or snapshot wrong");
  AST_HIGH_HOLD: assert property (
    !(reg_rd && reg_addr == RLSC_ADDR_PEAK_LO) && !sw_reset |=> $stable(peak_amplitude_high))
    else $error("peak upper bits moved without a read");
endmodule

bind rlsc_ctrl rlsc_ctrl_asserts u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_reset(sw_reset),
  .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .peak_valid(peak_valid),
  .peak_value(peak_value), .sqm_value(sqm_value), .sqm_threshold(sqm_threshold),
  .lock_loss(lock_loss), .digital_loss_assert_count(digital_loss_assert_count),
  .digital_loss_clear_count(digital_loss_clear_count),
  .signal_loss_pin(signal_loss_pin), .peak_amplitude_high(peak_amplitude_high));

`default_nettype wire

// ---- rlsc_ctrl_tb_top.sv ----
// testbench: register-level tests of the loss-of-signal control bank
`default_nettype none

`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module rlsc_ctrl_tb_top
  import rlsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys = 1'b0;
  logic                  arst_n = 1'b0;
  logic [7:0]            reg_addr = 8'h00;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_rdata;
  logic                  sw_reset = 1'b0;
  logic                  rx_bit_valid = 1'b0;
  logic                  rx_bit = 1'b0;
  logic                  peak_valid = 1'b0;
  logic [9:0]            peak_value = 10'h000;
  logic [RLSC_SQM_W-1:0] sqm_value = 16'h0014;
  logic [RLSC_SQM_W-1:0] sqm_threshold = 16'h000A;
  logic                  lock_loss = 1'b0;
  logic [7:0]            a_cnt = 8'h00;
  logic [7:0]            c_cnt = 8'h00;
  logic                  signal_loss_pin;
  logic [1:0]            peak_amplitude_high;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  rlsc_dmode_t           m;
  logic                  b;
  logic                  last;
  logic                  on;
  // the off mode comes first so its run shows no alarm
  rlsc_dmode_t           modes [5] = '{RLSC_DMODE_OFF, RLSC_DMODE_ZEROS, RLSC_DMODE_ONES,
                                       RLSC_DMODE_EITHER, RLSC_DMODE_EITHER};
  logic                  bitv [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  // counts start at zero so the mode sweep runs 2048 bits and one clear field
  rlsc_ctrl dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_reset(sw_reset),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .peak_valid(peak_valid),
    .peak_value(peak_value), .sqm_value(sqm_value), .sqm_threshold(sqm_threshold),
    .lock_loss(lock_loss), .digital_loss_assert_count(a_cnt),
    .digital_loss_clear_count(c_cnt), .signal_loss_pin(signal_loss_pin),
    .peak_amplitude_high(peak_amplitude_high));

  always #2 clk_sys = ~clk_sys;

  // hang guard, about twice the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask

  // status read plus the pin itself, which must agree with bit 0
  task automatic fl(input logic [7:0] e);
    rd(RLSC_ADDR_FLAGS, e);
    `CHK(signal_loss_pin, e[0])
  endtask

  task automatic run(input logic v, input int n);
    @(negedge clk_sys);
    rx_bit_valid = 1'b1;
    rx_bit = v;
    repeat (n) @(negedge clk_sys);
    rx_bit_valid = 1'b0;
  endtask

  task automatic pk(input logic [9:0] v);
    @(negedge clk_sys);
    peak_valid = 1'b1;
    peak_value = v;
    @(negedge clk_sys);
    peak_valid = 1'b0;
  endtask

  task automatic defaults();
    rd(RLSC_ADDR_ENABLE, 8'h01);
    rd(RLSC_ADDR_FLAGS, 8'h00);
    rd(RLSC_ADDR_LEVEL_LO, 8'h0F);
    rd(RLSC_ADDR_LEVEL_HYS, 8'h70);
    rd(RLSC_ADDR_PEAK_LO, 8'h00);
    `CHK(peak_amplitude_high, 2'h0)
  endtask

  initial begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    defaults();
    rd(8'h0E, 8'h00);
    wr(RLSC_ADDR_ENABLE, 8'hFF);
    rd(RLSC_ADDR_ENABLE, 8'h0F);
    wr(RLSC_ADDR_LEVEL_HYS, 8'hFF);
    rd(RLSC_ADDR_LEVEL_HYS, 8'hF3);
    wr(RLSC_ADDR_FLAGS, 8'hFF);
    fl(8'h00);
    wr(RLSC_ADDR_PEAK_LO, 8'hFF);
    rd(RLSC_ADDR_PEAK_LO, 8'h00);
    // quality source: flag shows even when disabled, lock loss masks it
    wr(RLSC_ADDR_ENABLE, 8'h00);
    sqm_value = 16'h0005;
    repeat (3) @(negedge clk_sys);
    fl(8'h10);
    wr(RLSC_ADDR_ENABLE, 8'h08);
    fl(8'h11);
    lock_loss = 1'b1;
    repeat (3) @(negedge clk_sys);
    fl(8'h00);
    lock_loss = 1'b0;
    sqm_value = 16'h0014;
    // analog source: threshold 300 kept inside 10..400, release above 375
    wr(RLSC_ADDR_ENABLE, 8'h00);
    wr(RLSC_ADDR_LEVEL_LO, 8'h2C);
    wr(RLSC_ADDR_LEVEL_HYS, 8'h41);
    rd(RLSC_ADDR_LEVEL_LO, 8'h2C);
    pk(10'h12B);
    fl(8'h02);
    wr(RLSC_ADDR_ENABLE, 8'h01);
    fl(8'h03);
    pk(10'h177);
    fl(8'h03);
    pk(10'h178);
    fl(8'h00);
    rd(RLSC_ADDR_PEAK_LO, 8'h78);
    `CHK(peak_amplitude_high, 2'h1)
    // digital source, every mode; one bit short of the run first
    last = 1'b0;
    for (int i = 0; i < 5; i++) begin
      m = modes[i];
      b = bitv[i];
      on = (m != RLSC_DMODE_OFF);
      wr(RLSC_ADDR_ENABLE, {5'h00, m, 1'b0});
      run(!b, 1);
      run(b, 2047);
      fl({4'h0, last, 3'h0});
      run(b, 1);
      if (on) last = b;
      fl({4'h0, last, on, 1'b0, on});
      run(!b, 1024);
      fl({4'h0, last, 3'h0});
    end
    // programmed counts: 7168-bit run, then 17 fields with transitions
    a_cnt = 8'h01;
    c_cnt = 8'h01;
    wr(RLSC_ADDR_ENABLE, 8'h02);
    run(1'b0, 7167);
    fl(8'h00);
    run(1'b0, 1);
    fl(8'h05);
    for (int k = 0; k < 17; k++) begin
      run(1'b1, 512);
      run(1'b0, 512);
      if (k == 15) fl(8'h05);
    end
    fl(8'h00);
    // soft reset brings every register back
    wr(RLSC_ADDR_LEVEL_LO, 8'h55);
    rd(RLSC_ADDR_LEVEL_LO, 8'h55);
    @(negedge clk_sys);
    sw_reset = 1'b1;
    @(negedge clk_sys);
    sw_reset = 1'b0;
    defaults();
    give_verdict();
  end
endmodule

`default_nettype wire
